// >>> rtl/camera_output_line_selector.sv
// output line source selector with register slave and lamp drive
//
// How it works
// (RULE1) each output line picks one of fifteen sources
// (RULE2) both lines select frame-trigger-wait after reset
// (RULE3) frame-trigger-wait low from exposure to image out
// (RULE4) frame-trigger-internal is the trigger, delayed
// (RULE5) exposure-active high while the sensor exposes
// (RULE6) acquisition-wait low during transfer to host
// (RULE7) acquisition-trigger-internal marks transfer start
// (RULE8) sensor-readout source follows frame valid
// (RULE9) debounced input lines are selectable sources
// (RULE10) two software-set static user output levels
// (RULE11) timer-0 active offered as a source
// (RULE12) software signals and logic block selectable
// (RULE13) pulse-per-second: 1 s square wave, half duty
// (RULE14) green lamp gigabit, yellow blinks on traffic
// (RULE15) open-collector line drives only as output
// (RULE16) line outputs registered after the source mux
// (RULE17) pulses shorter than debounce time are dropped
//
// Register access over AXI4-Lite and the register addresses are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
`include "line_selector_params.svh"

module camera_output_line_selector #(
   parameter int unsigned ADDR_W    = 8,
   parameter int unsigned DEB_W     = 16,
   parameter int unsigned TRIG_DLY  = `TRIG_DLY_CYCLES,
   parameter int unsigned PPS_HALF  = `PPS_HALF_CYCLES,
   parameter int unsigned BLINK_CYC = `BLINK_CYCLES
) (
   // clock and reset
   input  wire logic              clk,
   input  wire logic              nrst,
   // axi4-lite write address
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   // axi4-lite write data
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   // axi4-lite write response
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   // axi4-lite read address
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   // axi4-lite read data
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   // internal camera sources
   input  wire logic              trigger_in,
   input  wire logic              exposure_active,
   input  wire logic              frame_valid,
   input  wire logic              transfer_busy,
   input  wire logic              transfer_start,
   input  wire logic              timer0_active,
   input  wire logic              sw_signal0,
   input  wire logic              sw_signal1,
   input  wire logic              logic_block0,
   // network status
   input  wire logic              link_gigabit,
   input  wire logic              link_activity,
   // pins
   input  wire logic              isolated_input_line,
   output logic                   isolated_output_line,
   input  wire logic              bidir_line_i,
   output logic                   bidir_line_o,
   output logic                   bidir_line_oe_n,
   output logic                   led_green,
   output logic                   led_yellow
);

   // ------------------------------------------------------------
   // register slave
   // ------------------------------------------------------------
   logic [ADDR_W-1:0] awaddr_q;
   logic [31:0]       wdata_q;
   logic [3:0]        wstrb_q;
   logic              aw_full_q;
   logic              w_full_q;
   logic              awready_q;
   logic              wready_q;
   logic              bvalid_q;
   logic [1:0]        bresp_q;
   logic              arready_q;
   logic              rvalid_q;
   logic [1:0]        rresp_q;
   logic [31:0]       rdata_q;
   logic [31:0]       sel_q;
   logic [31:0]       ctrl_q;
   logic [DEB_W-1:0]  deb_q;
   logic [31:0]       wmask;
   logic [31:0]       stat;
   logic              aw_hs;
   logic              w_hs;
   logic              b_hs;
   logic              ar_hs;
   logic              r_hs;
   logic              do_write;
   logic              wr_sel;
   logic              wr_ctrl;
   logic              wr_deb;
   logic              wr_ok;

   assign aw_hs    = s_axi_awvalid & awready_q;
   assign w_hs     = s_axi_wvalid & wready_q;
   assign b_hs     = bvalid_q & s_axi_bready;
   assign ar_hs    = s_axi_arvalid & arready_q;
   assign r_hs     = rvalid_q & s_axi_rready;
   assign do_write = aw_full_q & w_full_q & ~bvalid_q;
   assign wmask    = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}},
                      {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
   assign wr_sel   = do_write && awaddr_q == `REG_SEL_OFS;
   assign wr_ctrl  = do_write && awaddr_q == `REG_CTRL_OFS;
   assign wr_deb   = do_write && awaddr_q == `REG_DEB_OFS;
   assign wr_ok    = wr_sel | wr_ctrl | wr_deb
                     | (awaddr_q == `REG_STAT_OFS);

   // address and data are taken in either order; both stay
   // refused until the response has been accepted
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         awready_q <= 1'b1;
      end else if (aw_hs) begin
         awready_q <= 1'b0;
      end else if (b_hs) begin
         awready_q <= 1'b1;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         wready_q <= 1'b1;
      end else if (w_hs) begin
         wready_q <= 1'b0;
      end else if (b_hs) begin
         wready_q <= 1'b1;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         aw_full_q <= 1'b0;
         awaddr_q  <= '0;
      end else if (aw_hs) begin
         aw_full_q <= 1'b1;
         awaddr_q  <= s_axi_awaddr;
      end else if (do_write) begin
         aw_full_q <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         w_full_q <= 1'b0;
         wdata_q  <= '0;
         wstrb_q  <= '0;
      end else if (w_hs) begin
         w_full_q <= 1'b1;
         wdata_q  <= s_axi_wdata;
         wstrb_q  <= s_axi_wstrb;
      end else if (do_write) begin
         w_full_q <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         bvalid_q <= 1'b0;
         bresp_q  <= line_selector_pkg::RESP_OKAY;
      end else if (do_write) begin
         bvalid_q <= 1'b1;
         bresp_q  <= wr_ok ? line_selector_pkg::RESP_OKAY
                           : line_selector_pkg::RESP_SLVERR;
      end else if (b_hs) begin
         bvalid_q <= 1'b0;
      end
   end

   // writable registers, byte lanes honoured
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         sel_q <= `SEL_RST; // [RULE2]
      end else if (wr_sel) begin
         sel_q <= (sel_q & ~wmask) | (wdata_q & wmask); // [RULE1]
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ctrl_q <= `CTRL_RST;
      end else if (wr_ctrl) begin
         ctrl_q <= (ctrl_q & ~wmask) | (wdata_q & wmask); // [RULE10]
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         deb_q <= DEB_W'(`DEB_RST);
      end else if (wr_deb) begin
         deb_q <= (deb_q & ~wmask[DEB_W-1:0])
                  | (wdata_q[DEB_W-1:0] & wmask[DEB_W-1:0]);
      end
   end

   // read channel: one cycle after the address is taken
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         arready_q <= 1'b1;
      end else if (ar_hs) begin
         arready_q <= 1'b0;
      end else if (r_hs) begin
         arready_q <= 1'b1;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rvalid_q <= 1'b0;
         rresp_q  <= line_selector_pkg::RESP_OKAY;
         rdata_q  <= '0;
      end else if (ar_hs) begin
         rvalid_q <= 1'b1;
         rresp_q  <= line_selector_pkg::RESP_OKAY;
         unique case (s_axi_araddr)
            `REG_SEL_OFS:  rdata_q <= sel_q & 32'h0000_0f0f;
            `REG_CTRL_OFS: rdata_q <= ctrl_q & 32'h0000_0007;
            `REG_DEB_OFS:  rdata_q <= 32'(deb_q);
            `REG_STAT_OFS: rdata_q <= stat;
            default: begin
               rdata_q <= '0;
               rresp_q <= line_selector_pkg::RESP_SLVERR;
            end
         endcase
      end else if (r_hs) begin
         rvalid_q <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // pin synchronisers and debounce
   // ------------------------------------------------------------
   logic [1:0] iso_sync_q;
   logic [1:0] bidir_sync_q;
   logic       deb_iso;
   logic       deb_bidir;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         iso_sync_q   <= '0;
         bidir_sync_q <= '0;
      end else begin
         iso_sync_q   <= {iso_sync_q[0], isolated_input_line};
         bidir_sync_q <= {bidir_sync_q[0], bidir_line_i};
      end
   end

   line_debouncer #(.CNT_W(DEB_W)) u_deb_iso (
      .clk        (clk),
      .nrst       (nrst),
      .level_in   (iso_sync_q[1]),
      .deb_cycles (deb_q),
      .level_out  (deb_iso)
   ); // [RULE9]

   line_debouncer #(.CNT_W(DEB_W)) u_deb_bidir (
      .clk        (clk),
      .nrst       (nrst),
      .level_in   (bidir_sync_q[1]),
      .deb_cycles (deb_q),
      .level_out  (deb_bidir)
   ); // [RULE9]

   // ------------------------------------------------------------
   // derived sources
   // ------------------------------------------------------------
   logic                exp_d_q;
   logic                fv_d_q;
   logic                frame_busy_q;
   logic [TRIG_DLY-1:0] trig_dly_q;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         exp_d_q <= 1'b0;
         fv_d_q  <= 1'b0;
      end else begin
         exp_d_q <= exposure_active;
         fv_d_q  <= frame_valid;
      end
   end

   // busy from exposure start until the frame has been read out;
   // a new exposure edge wins over the end of the previous frame
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         frame_busy_q <= 1'b0;
      end else if (exposure_active && !exp_d_q) begin
         frame_busy_q <= 1'b1; // [RULE3]
      end else if (fv_d_q && !frame_valid) begin
         frame_busy_q <= 1'b0; // [RULE3]
      end
   end

   // fixed processing delay; length is a parameter
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         trig_dly_q <= '0;
      end else if (TRIG_DLY > 1) begin
         trig_dly_q <= {trig_dly_q[TRIG_DLY-2:0], trigger_in}; // [RULE4]
      end else begin
         trig_dly_q <= {TRIG_DLY{trigger_in}}; // [RULE4]
      end
   end

   // ------------------------------------------------------------
   // pulse per second and lamp blink
   // ------------------------------------------------------------
   logic [31:0] pps_cnt_q;
   logic        pps_q;
   logic [31:0] blink_cnt_q;
   logic        blink_q;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pps_cnt_q <= '0;
         pps_q     <= 1'b0;
      end else if (pps_cnt_q == PPS_HALF - 1) begin
         pps_cnt_q <= '0;
         pps_q     <= ~pps_q; // [RULE13]
      end else begin
         pps_cnt_q <= pps_cnt_q + 32'h1;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         blink_cnt_q <= '0;
         blink_q     <= 1'b0;
      end else if (blink_cnt_q == BLINK_CYC - 1) begin
         blink_cnt_q <= '0;
         blink_q     <= ~blink_q;
      end else begin
         blink_cnt_q <= blink_cnt_q + 32'h1;
      end
   end

   // ------------------------------------------------------------
   // source mux and registered outputs
   // ------------------------------------------------------------
   logic [14:0] srcs;
   logic [3:0]  iso_sel;
   logic [3:0]  bidir_sel;
   logic        iso_q;
   logic        bidir_q;
   logic        oe_n_q;
   logic        green_q;
   logic        yellow_q;

   assign srcs[line_selector_pkg::SRC_FRAME_TRIG_WAIT] = ~frame_busy_q;
   assign srcs[line_selector_pkg::SRC_FRAME_TRIG_INT]  =
          trig_dly_q[TRIG_DLY-1];
   assign srcs[line_selector_pkg::SRC_EXPOSURE_ACTIVE] =
          exposure_active; // [RULE5]
   assign srcs[line_selector_pkg::SRC_ACQ_TRIG_WAIT]   =
          ~transfer_busy; // [RULE6]
   assign srcs[line_selector_pkg::SRC_ACQ_TRIG_INT]    =
          transfer_start; // [RULE7]
   assign srcs[line_selector_pkg::SRC_SENSOR_READOUT]  =
          frame_valid; // [RULE8]
   assign srcs[line_selector_pkg::SRC_DEB_ISO_IN]      = deb_iso;
   assign srcs[line_selector_pkg::SRC_DEB_BIDIR]       = deb_bidir;
   assign srcs[line_selector_pkg::SRC_USER_OUT1]       =
          ctrl_q[`CTRL_USER1_BIT]; // [RULE10]
   assign srcs[line_selector_pkg::SRC_USER_OUT2]       =
          ctrl_q[`CTRL_USER2_BIT]; // [RULE10]
   assign srcs[line_selector_pkg::SRC_TIMER0_ACTIVE]   =
          timer0_active; // [RULE11]
   assign srcs[line_selector_pkg::SRC_SW_SIGNAL0]      =
          sw_signal0; // [RULE12]
   assign srcs[line_selector_pkg::SRC_SW_SIGNAL1]      =
          sw_signal1; // [RULE12]
   assign srcs[line_selector_pkg::SRC_LOGIC_BLOCK0]    =
          logic_block0; // [RULE12]
   assign srcs[line_selector_pkg::SRC_PPS]             = pps_q;

   assign iso_sel   = sel_q[`SEL_ISO_LSB +: 4];
   assign bidir_sel = sel_q[`SEL_BIDIR_LSB +: 4];

   // code 15 is not a source; it parks the line low.
   // registering after the mux keeps a select change glitch free
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         iso_q   <= 1'b0;
         bidir_q <= 1'b0;
      end else begin
         iso_q   <= (iso_sel != 4'hf) && srcs[iso_sel]; // [RULE1] [RULE16]
         bidir_q <= (bidir_sel != 4'hf) && srcs[bidir_sel]; // [RULE16]
      end
   end

   // line stays released while configured as input
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         oe_n_q <= 1'b1;
      end else begin
         oe_n_q <= ~ctrl_q[`CTRL_DIR_BIT]; // [RULE15]
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         green_q  <= 1'b0;
         yellow_q <= 1'b0;
      end else begin
         green_q  <= link_gigabit; // [RULE14]
         yellow_q <= link_activity & blink_q; // [RULE14]
      end
   end

   assign stat = {26'h0, link_gigabit, pps_q, deb_bidir, deb_iso,
                  bidir_q, iso_q};

   assign s_axi_awready        = awready_q;
   assign s_axi_wready         = wready_q;
   assign s_axi_bvalid         = bvalid_q;
   assign s_axi_bresp          = bresp_q;
   assign s_axi_arready        = arready_q;
   assign s_axi_rvalid         = rvalid_q;
   assign s_axi_rresp          = rresp_q;
   assign s_axi_rdata          = rdata_q;
   assign isolated_output_line = iso_q;
   assign bidir_line_o         = bidir_q;
   assign bidir_line_oe_n      = oe_n_q;
   assign led_green            = green_q;
   assign led_yellow           = yellow_q;

endmodule
`default_nettype wire

// >>> rtl/line_debouncer.sv
// glitch filter for one synchronised input line
`timescale 1ns/100ps
`default_nettype none
`include "line_selector_params.svh"

module line_debouncer #(
   parameter int unsigned CNT_W = 16
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             nrst,
   // line
   input  wire logic             level_in,
   input  wire logic [CNT_W-1:0] deb_cycles,
   output logic                  level_out
);

   logic [CNT_W-1:0] cnt_q;
   logic             out_q;

   // a level must hold for deb_cycles before it is passed on, so a
   // pulse shorter than that never reaches the output
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cnt_q <= '0;
      end else if (level_in == out_q) begin
         cnt_q <= '0;
      end else if (cnt_q < deb_cycles) begin
         cnt_q <= cnt_q + {{(CNT_W-1){1'b0}}, 1'b1}; // [RULE17]
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         out_q <= 1'b0;
      end else if (level_in != out_q && cnt_q >= deb_cycles) begin
         out_q <= level_in; // [RULE17]
      end
   end

   assign level_out = out_q;

endmodule
`default_nettype wire

// >>> rtl/line_selector_params.svh
// offsets, field positions, reset values and timing counts
`ifndef LINE_SELECTOR_PARAMS_SVH
`define LINE_SELECTOR_PARAMS_SVH

// register byte offsets
`define REG_SEL_OFS     8'h00
`define REG_CTRL_OFS    8'h04
`define REG_DEB_OFS     8'h08
`define REG_STAT_OFS    8'h0c

// select register fields
`define SEL_ISO_LSB     0
`define SEL_BIDIR_LSB   8

// control register fields
`define CTRL_DIR_BIT    0
`define CTRL_USER1_BIT  1
`define CTRL_USER2_BIT  2

// reset values
`define SEL_RST         32'h0000_0000
`define CTRL_RST        32'h0000_0000
`define DEB_RST         16'h00c8

// clock and timing
`define CLK_FREQ_MHZ    200
`define PPS_PERIOD_MS   1000
`define BLINK_HALF_MS   50
`define PPS_HALF_CYCLES ((`PPS_PERIOD_MS * 1000 * `CLK_FREQ_MHZ) / 2)
`define BLINK_CYCLES    (`BLINK_HALF_MS * 1000 * `CLK_FREQ_MHZ)
`define TRIG_DLY_CYCLES 4

`endif

// >>> rtl/line_selector_pkg.sv
// types shared by the output line selector
package line_selector_pkg;

   typedef enum logic [3:0] {
      SRC_FRAME_TRIG_WAIT = 4'h0,
      SRC_FRAME_TRIG_INT  = 4'h1,
      SRC_EXPOSURE_ACTIVE = 4'h2,
      SRC_ACQ_TRIG_WAIT   = 4'h3,
      SRC_ACQ_TRIG_INT    = 4'h4,
      SRC_SENSOR_READOUT  = 4'h5,
      SRC_DEB_ISO_IN      = 4'h6,
      SRC_DEB_BIDIR       = 4'h7,
      SRC_USER_OUT1       = 4'h8,
      SRC_USER_OUT2       = 4'h9,
      SRC_TIMER0_ACTIVE   = 4'ha,
      SRC_SW_SIGNAL0      = 4'hb,
      SRC_SW_SIGNAL1      = 4'hc,
      SRC_LOGIC_BLOCK0    = 4'hd,
      SRC_PPS             = 4'he
   } line_src_t;

   typedef enum logic [1:0] {
      RESP_OKAY   = 2'h0,
      RESP_SLVERR = 2'h2
   } axi_resp_t;

endpackage

// >>> test/camera_output_line_selector_tb_top.sv
// self-checking bench for the output line selector
`timescale 1ns/100ps
`default_nettype none
`include "line_selector_params.svh"
module camera_output_line_selector_tb_top;
   localparam int unsigned PPS_H = 10;
   logic        clk = 1'h0, nrst = 1'h0;
   logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
   logic [3:0]  s_axi_wstrb = 4'hf;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, isolated_input_line, isolated_output_line;
   logic bidir_line_i, bidir_line_o, bidir_line_oe_n, led_green, led_yellow;
   logic trigger_in = 1'h0, exposure_active = 1'h0, frame_valid = 1'h0;
   logic transfer_busy = 1'h0, transfer_start = 1'h0, timer0_active = 1'h0;
   logic sw_signal0 = 1'h0, sw_signal1 = 1'h0, logic_block0 = 1'h0;
   logic link_gigabit = 1'h0, link_activity = 1'h0;
   logic iso_drv = 1'h0, ext_en = 1'h0, ext_val = 1'h0, e;
   int   error_cnt = 0, checked = 0, k, n, i;
   logic [3:0] codes [8] = '{4'h2, 4'h3, 4'h4, 4'h5, 4'ha, 4'hb, 4'hc, 4'hd};

   // pps and blink shortened so the run stays short
   camera_output_line_selector #(.PPS_HALF(PPS_H), .BLINK_CYC(4)) uut (
      .clk, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .trigger_in, .exposure_active,
      .frame_valid, .transfer_busy, .transfer_start, .timer0_active,
      .sw_signal0, .sw_signal1, .logic_block0, .link_gigabit,
      .link_activity, .isolated_input_line, .isolated_output_line,
      .bidir_line_i, .bidir_line_o, .bidir_line_oe_n, .led_green,
      .led_yellow);
   line_partner far (.bidir_o(bidir_line_o), .bidir_oe_n(bidir_line_oe_n),
      .iso_level(iso_drv), .ext_en(ext_en), .ext_val(ext_val),
      .iso_pin(isolated_input_line), .bidir_wire(bidir_line_i));

   always #2.5 clk = ~clk;

   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task results;
      $display("checks %0d errors %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task cyc(input int c);
      repeat (c) @(posedge clk);
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      for (n = 0; n < 50; n++) begin
         @(posedge clk);
         if (s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wready) s_axi_wvalid <= 1'h0;
         if (s_axi_bvalid === 1'h1) break;
      end
      if (n == 50) begin error_cnt++; results(); end
      s_axi_bready <= 1'h0;
      chk("bresp", 32'(s_axi_bresp), 32'(er));
   endtask
   task rd_reg(input logic [7:0] a, input logic [1:0] er);
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      for (n = 0; n < 50; n++) begin
         @(posedge clk);
         if (s_axi_arready) s_axi_arvalid <= 1'h0;
         if (s_axi_rvalid === 1'h1) break;
      end
      if (n == 50) begin error_cnt++; results(); end
      s_axi_rready <= 1'h0;
      rd = s_axi_rdata;
      chk("rresp", 32'(s_axi_rresp), 32'(er));
   endtask
   task set_src(input logic [3:0] c, input logic v);
      case (c)
         4'h2: exposure_active <= v;
         4'h3: transfer_busy <= v;
         4'h4: transfer_start <= v;
         4'h5: frame_valid <= v;
         4'ha: timer0_active <= v;
         4'hb: sw_signal0 <= v;
         4'hc: sw_signal1 <= v;
         default: logic_block0 <= v;
      endcase
   endtask
   task lines(input logic iso, input logic bid);
      cyc(4);
      chk("iso line", 32'(isolated_output_line), 32'(iso));
      chk("bidir line", 32'(bidir_line_o), 32'(bid));
   endtask

   initial begin
      cyc(4);
      nrst <= 1'h1;
      lines(1'h1, 1'h1);
      chk("oe_n rst", 32'(bidir_line_oe_n), 32'h1);
      rd_reg(`REG_SEL_OFS, 2'h0);
      chk("sel rst", rd, `SEL_RST);
      rd_reg(`REG_DEB_OFS, 2'h0);
      chk("deb rst", rd, 32'(`DEB_RST));
      rd_reg(8'h10, 2'h2);
      chk("unmapped", rd, 32'h0);
      wr(8'h10, 32'h0000_0505, 2'h2);
      rd_reg(`REG_SEL_OFS, 2'h0);
      chk("sel kept", rd, 32'h0);
      // level sources; acquisition wait is busy inverted
      for (i = 0; i < 8; i++) begin
         wr(`REG_SEL_OFS, {20'h0, codes[i], 4'h0, codes[i]}, 2'h0);
         e = (codes[i] != 4'h3);
         set_src(codes[i], 1'h1);
         lines(e, e);
         set_src(codes[i], 1'h0);
         lines(~e, ~e);
      end
      wr(`REG_SEL_OFS, 32'h0000_0000, 2'h0);
      exposure_active <= 1'h1;
      lines(1'h0, 1'h0);
      exposure_active <= 1'h0;
      frame_valid <= 1'h1;
      lines(1'h0, 1'h0);
      frame_valid <= 1'h0;
      lines(1'h1, 1'h1);
      wr(`REG_SEL_OFS, 32'h0000_0101, 2'h0);
      trigger_in <= 1'h1;
      cyc(`TRIG_DLY_CYCLES + 1);
      chk("trig early", 32'(isolated_output_line), 32'h0);
      lines(1'h1, 1'h1);
      trigger_in <= 1'h0;
      wr(`REG_CTRL_OFS, 32'h0000_0002, 2'h0);
      wr(`REG_SEL_OFS, 32'h0000_0908, 2'h0);
      lines(1'h1, 1'h0);
      wr(`REG_CTRL_OFS, 32'h0000_0004, 2'h0);
      lines(1'h0, 1'h1);
      chk("oe_n input", 32'(bidir_line_oe_n), 32'h1);
      wr(`REG_CTRL_OFS, 32'h0000_0005, 2'h0);
      wr(`REG_SEL_OFS, 32'hffff_ffff, 2'h0);
      lines(1'h0, 1'h0);
      chk("oe_n output", 32'(bidir_line_oe_n), 32'h0);
      wr(`REG_CTRL_OFS, 32'h0000_0000, 2'h0);
      wr(`REG_DEB_OFS, 32'h0000_000a, 2'h0);
      wr(`REG_SEL_OFS, 32'h0000_0706, 2'h0);
      iso_drv <= 1'h1;
      cyc(5);
      iso_drv <= 1'h0;
      lines(1'h0, 1'h1);
      iso_drv <= 1'h1;
      ext_en <= 1'h1;
      cyc(26);
      lines(1'h1, 1'h0);
      ext_en <= 1'h0;
      wr(`REG_SEL_OFS, 32'h0000_0e0e, 2'h0);
      for (n = 0; n < 50 && isolated_output_line !== 1'h0; n++) cyc(1);
      for (n = 0; n < 50 && isolated_output_line !== 1'h1; n++) cyc(1);
      for (k = 0; k < 50 && isolated_output_line === 1'h1; k++) cyc(1);
      chk("pps high", k, PPS_H);
      for (k = 0; k < 50 && isolated_output_line === 1'h0; k++) cyc(1);
      chk("pps low", k, PPS_H);
      link_gigabit <= 1'h1;
      rd_reg(`REG_STAT_OFS, 2'h0);
      chk("green", 32'(led_green), 32'h1);
      chk("stat giga", 32'(rd[5]), 32'h1);
      link_activity <= 1'h1;
      k = 0;
      repeat (20) begin
         cyc(1);
         k += int'(led_yellow === 1'h1);
      end
      chk("blink", 32'(k > 4 && k < 16), 32'h1);
      link_activity <= 1'h0;
      link_gigabit <= 1'h0;
      cyc(3);
      chk("yellow off", 32'(led_yellow), 32'h0);
      chk("green off", 32'(led_green), 32'h0);
      results();
   end
endmodule

bind camera_output_line_selector line_selector_sva chk_i (
   .clk, .nrst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
   .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
   .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
   .s_axi_rready, .link_gigabit, .link_activity, .led_green, .led_yellow);
`default_nettype wire

// >>> test/line_partner.sv
// external equipment model wired to the camera line pins
`timescale 1ns/100ps
`default_nettype none
module line_partner (
   // camera side
   input  wire logic bidir_o,
   input  wire logic bidir_oe_n,
   // bench control
   input  wire logic iso_level,
   input  wire logic ext_en,
   input  wire logic ext_val,
   // pins
   output logic      iso_pin,
   output logic      bidir_wire
);
   // pull-up on the open-collector wire: whoever pulls low wins
   assign bidir_wire = ~((~bidir_oe_n & ~bidir_o) | (ext_en & ~ext_val));
   assign iso_pin    = iso_level;
endmodule
`default_nettype wire

// >>> test/line_selector_sva.sv
// port assertions for the output line selector
`timescale 1ns/100ps
`default_nettype none
module line_selector_sva (
   // clock and reset
   input wire logic        clk,
   input wire logic        nrst,
   // register bus
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   // lamps
   input wire logic        link_gigabit,
   input wire logic        link_activity,
   input wire logic        led_green,
   input wire logic        led_yellow
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   sequence wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence rd_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence
   a_write_answer: assert property (wr_taken |-> ##2 s_axi_bvalid)
      else $error("write response missing");
   a_write_hold: assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
   a_write_block: assert property (s_axi_bvalid
      |-> !s_axi_awready && !s_axi_wready) else $error("write not blocked");
   a_read_answer: assert property (rd_taken |=> s_axi_rvalid)
      else $error("read data missing");
   a_read_hold: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
   a_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read not blocked");
   a_green_lamp: assert property (
      1 |=> led_green == $past(link_gigabit)) else $error("green lamp wrong");
   a_yellow_dark: assert property (!link_activity |=> !led_yellow)
      else $error("yellow lit without traffic");
endmodule
`default_nettype wire
